// ### src/emc_defs.svh
// Register offsets, field positions, reset values and timing counts of the memory config block
`ifndef EMC_DEFS_SVH
`define EMC_DEFS_SVH
// Register byte offsets
`define EMC_OFS_CFG_ONE 8'h00
`define EMC_OFS_CFG_TWO 8'h04
// Writable bits and reset values
`define EMC_CFG1_WMASK 32'h7EF8_0BFF
`define EMC_CFG2_WMASK 32'hFFF8_7EFF
`define EMC_CFG1_RESET 32'h0000_00FF
`define EMC_CFG2_RESET 32'h7C40_0000
// Fields of memory_config_one
`define EMC_C1_PBRDY 30
`define EMC_C1_ABRDY 29
`define EMC_C1_IOWDH 27
`define EMC_C1_IOBRDY 26
`define EMC_C1_BEXC 25
`define EMC_C1_IOWS 20
`define EMC_C1_IOEN 19
`define EMC_C1_PRWEN 11
`define EMC_C1_PRWDH 8
`define EMC_C1_PRWWS 4
`define EMC_C1_PRRWS 0
// Fields of memory_config_two
`define EMC_C2_SDRREF 31
`define EMC_C2_TRP 30
`define EMC_C2_TRFC 27
`define EMC_C2_SDRCAS 26
`define EMC_C2_SDRBS 23
`define EMC_C2_SDRCLS 21
`define EMC_C2_SDRCMD 19
`define EMC_C2_SE 14
`define EMC_C2_SI 13
`define EMC_C2_RAMBS 9
`define EMC_C2_RAMBRDY 7
`define EMC_C2_RAMRMW 6
`define EMC_C2_RAMWDH 4
`define EMC_C2_RAMWWS 2
`define EMC_C2_RAMRWS 0
// Trap codes by access type
`define EMC_TRAP_FETCH 8'h01
`define EMC_TRAP_LOAD 8'h09
`define EMC_TRAP_STORE 8'h2B
// Timing
`define EMC_CLK_NS 50
`define EMC_REFRESH_NS 15600
`define EMC_REFRESH_CYC (`EMC_REFRESH_NS / `EMC_CLK_NS)
`define EMC_TRP_BASE 2
`define EMC_TRFC_BASE 3
`define EMC_TLMR_CYC 2
`define EMC_CAS_BASE 2
`define EMC_RAM_CS_READY 4
`endif

// ### src/emc_pkg.sv
// Types shared by the memory config block
package emc_pkg;
  // Areas on the external bus
  typedef enum logic [1:0] {EMC_AREA_PROM, EMC_AREA_SRAM, EMC_AREA_IO, EMC_AREA_SDRAM} emc_area_t;
  // SDRAM commands as coded in the command field
  typedef enum logic [1:0] {EMC_SD_NONE, EMC_SD_PRECHARGE, EMC_SD_REFRESH, EMC_SD_LOAD_MODE} emc_sdcmd_t;
  // Access sequencer states
  typedef enum logic [1:0] {EMC_IDLE, EMC_WAIT, EMC_READY} emc_state_t;
  // Whole state of the block
  typedef struct packed {
    logic [31:0] cfg1;
    logic [31:0] cfg2;
    logic [31:0] rdata;
    logic strap_done;
    logic rdy_meta;
    logic rdy_sync;
    emc_state_t state;
    logic [4:0] wcnt;
    logic rmw;
    logic acc_write;
    emc_area_t acc_area;
    logic acc_fetch;
    logic need_rdy;
    logic done;
    logic err;
    logic [7:0] trap;
    logic ext_active;
    logic ext_write;
    logic width8;
    logic [4:0] cs_n;
    logic sd_busy;
    logic sd_sw;
    logic [3:0] sd_cnt;
    emc_sdcmd_t sd_cmd;
    logic [15:0] ref_cnt;
    logic ref_pend;
    logic [1:0] cas_lat;
    logic [4:0] sd_bank_log2;
    logic [3:0] sd_col_log2;
    logic [4:0] sram_bank_log2;
  } emc_state_s_t;
endpackage

// ### src/emc_core.sv
// Memory configuration registers and external access sequencer
//
// Functional notes
// - PROM bus-ready enable holds each PROM access until ready input goes low.
// - Async ready mode synchronises ready; access ends at least one clock later.
// - I/O width code 00 gives 8-bit bus, 10 gives 32-bit bus.
// - I/O bus-ready enable extends I/O accesses until ready is asserted.
// - Bus-error enable turns external error into error response and trap code.
// - I/O wait-state field inserts its binary value, 0 to 15, as waits.
// - I/O area enable zero blocks I/O reads and writes.
// - PROM writes happen only while PROM write enable is set.
// - PROM width 00 is 8-bit, upper bit set is 32-bit; strapped at reset.
// - PROM wait fields insert twice their value; both reset to maximum.
// - 8-bit PROM with error correction loses the top fifth of each bank.
// - Periodic SDRAM auto-refresh only while refresh enable is set.
// - Precharge takes 2 or 3 clocks; refresh takes 3 plus field.
// - CAS bit selects latency 2 or 3; RAS-to-CAS follows it.
// - SDRAM bank size doubles from 4 MB at 000 to 512 MB.
// - Column codes give 256, 512, 1024; 11 gives 4096 or 2048.
// - Nonzero command field issues precharge, refresh or mode load, then clears.
// - SDRAM works only when enabled; with SRAM disable and SDRAM enabled, static accesses stop.
// - SRAM bank size doubles from 8 KB at 0000 to 256 MB.
// - RAM bus-ready enable extends accesses to RAM chip select 4.
// - RMW bit turns sub-word SRAM stores into read then full-word write.
// - SRAM width 00 is 8-bit, upper bit 32-bit; waits 0 to 3.
//
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "emc_defs.svh"

module emc_core
  import emc_pkg::*;
#(
  parameter int PROM_BANK_LOG2 = 28,
  parameter int REFRESH_CYCLES = `EMC_REFRESH_CYC
)
(
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic [7:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  input wire logic [1:0] i_strap_prom_width,
  input wire logic i_prom_edac_en,
  input wire logic i_acc_req,
  input wire emc_pkg::emc_area_t i_acc_area,
  input wire logic i_acc_write,
  input wire logic i_acc_fetch,
  input wire logic i_acc_subword,
  input wire logic [2:0] i_acc_bank,
  input wire logic [27:0] i_acc_offset,
  output logic o_acc_done,
  output logic o_acc_err,
  output logic [7:0] o_trap_code,
  input wire logic i_ext_ready_n,
  input wire logic i_ext_error_n,
  output logic o_ext_active,
  output logic o_ext_write,
  output logic o_ext_width8,
  output logic [4:0] o_static_chip_select_n,
  output emc_pkg::emc_sdcmd_t o_sd_cmd,
  output logic [1:0] o_sd_cas_latency,
  output logic [4:0] o_sd_bank_log2,
  output logic [3:0] o_sd_col_log2,
  output logic [4:0] o_sram_bank_log2
);
  import emc_pkg::*;

  emc_state_s_t s_reg;
  emc_state_s_t s_next;

  // ---------------------------------------------------------------
  // Field views of the configuration registers
  // ---------------------------------------------------------------
  logic [31:0] c1;
  logic [31:0] c2;
  logic dram_ctrl_enable;
  logic sram_off;
  logic rdy_seen;
  logic bus_err;
  logic [31:0] prom_off5;
  logic [31:0] prom_limit;

  assign c1 = s_reg.cfg1;
  assign c2 = s_reg.cfg2;
  assign dram_ctrl_enable = c2[`EMC_C2_SE];
  assign sram_off = dram_ctrl_enable & c2[`EMC_C2_SI];
  // Async mode looks only at the second synchroniser stage, costing two clocks
  assign rdy_seen = c1[`EMC_C1_ABRDY] ? ~s_reg.rdy_sync : ~i_ext_ready_n;
  assign bus_err = c1[`EMC_C1_BEXC] & ~i_ext_error_n;
  // Check bytes take the top fifth of a bank: offset*5 against bank*4
  assign prom_off5 = {4'h0, i_acc_offset} * 32'd5;
  assign prom_limit = 32'd1 << (PROM_BANK_LOG2 + 2);

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb
  begin
    logic blocked;
    logic [4:0] waits;
    logic nrdy;
    logic w8;
    logic [3:0] sd_t;
    logic [1:0] sw_cmd;
    blocked = 1'b0;
    waits = 5'h0_0;
    nrdy = 1'b0;
    w8 = 1'b0;
    sd_t = 4'h0;
    sw_cmd = c2[`EMC_C2_SDRCMD +: 2];
    s_next = s_reg;
    s_next.done = 1'b0;
    s_next.err = 1'b0;
    s_next.sd_cmd = EMC_SD_NONE;

    // Ready synchroniser; the first stage feeds only the second
    s_next.rdy_meta = i_ext_ready_n;
    s_next.rdy_sync = s_reg.rdy_meta;

    // Strap load on the first clock after reset release
    if (!s_reg.strap_done)
    begin
      s_next.strap_done = 1'b1;
      s_next.cfg1[`EMC_C1_PRWDH +: 2] = i_strap_prom_width;
    end

    // Register reads, answered in the next cycle only
    s_next.rdata = 32'h0000_0000;
    if (i_reg_rd)
    begin
      if (i_reg_addr == `EMC_OFS_CFG_ONE)
        s_next.rdata = c1;
      else if (i_reg_addr == `EMC_OFS_CFG_TWO)
        s_next.rdata = c2;
    end

    // Area decode of the current request
    unique case (i_acc_area)
      EMC_AREA_PROM:
      begin
        waits = i_acc_write ? {c1[`EMC_C1_PRWWS +: 4], 1'b0} : {c1[`EMC_C1_PRRWS +: 4], 1'b0};
        nrdy = c1[`EMC_C1_PBRDY];
        w8 = (c1[`EMC_C1_PRWDH +: 2] == 2'b00);
        blocked = i_acc_write & ~c1[`EMC_C1_PRWEN];
        if (w8 && i_prom_edac_en && (prom_off5 >= prom_limit))
          blocked = 1'b1;
      end
      EMC_AREA_SRAM:
      begin
        waits = i_acc_write ? {3'h0, c2[`EMC_C2_RAMWWS +: 2]} : {3'h0, c2[`EMC_C2_RAMRWS +: 2]};
        nrdy = c2[`EMC_C2_RAMBRDY] & (i_acc_bank == 3'(`EMC_RAM_CS_READY));
        w8 = (c2[`EMC_C2_RAMWDH +: 2] == 2'b00);
        blocked = sram_off | (i_acc_bank > 3'(`EMC_RAM_CS_READY));
      end
      EMC_AREA_IO:
      begin
        waits = {1'b0, c1[`EMC_C1_IOWS +: 4]};
        nrdy = c1[`EMC_C1_IOBRDY];
        w8 = (c1[`EMC_C1_IOWDH +: 2] == 2'b00);
        blocked = ~c1[`EMC_C1_IOEN];
      end
      EMC_AREA_SDRAM:
      begin
        waits = 5'(`EMC_CAS_BASE) + {4'h0, c2[`EMC_C2_SDRCAS]};
        blocked = ~dram_ctrl_enable | s_reg.sd_busy;
      end
    endcase

    // Access sequencer
    unique case (s_reg.state)
      EMC_IDLE:
      begin
        if (i_acc_req)
        begin
          s_next.acc_write = i_acc_write;
          s_next.acc_area = i_acc_area;
          s_next.acc_fetch = i_acc_fetch;
          if (blocked)
          begin
            s_next.done = 1'b1;
            s_next.err = 1'b1;
            s_next.trap = i_acc_fetch ? `EMC_TRAP_FETCH :
                          (i_acc_write ? `EMC_TRAP_STORE : `EMC_TRAP_LOAD);
          end
          else
          begin
            // Sub-word SRAM stores with the RMW bit set run a read phase first
            s_next.rmw = (i_acc_area == EMC_AREA_SRAM) & i_acc_write & i_acc_subword &
                         c2[`EMC_C2_RAMRMW];
            s_next.ext_write = i_acc_write & ~s_next.rmw;
            s_next.wcnt = s_next.rmw ? {3'h0, c2[`EMC_C2_RAMRWS +: 2]} : waits;
            s_next.need_rdy = nrdy;
            s_next.width8 = w8;
            s_next.ext_active = 1'b1;
            if (i_acc_area == EMC_AREA_SRAM)
              s_next.cs_n = ~(5'h0_1 << i_acc_bank);
            s_next.state = EMC_WAIT;
          end
        end
      end
      EMC_WAIT, EMC_READY:
      begin
        if (s_reg.state == EMC_WAIT && s_reg.wcnt != 5'h0_0)
          s_next.wcnt = s_reg.wcnt - 5'h0_1;
        else if (s_reg.state == EMC_WAIT && s_reg.need_rdy && !rdy_seen)
          s_next.state = EMC_READY;
        else if (s_reg.state == EMC_READY && !rdy_seen)
          s_next.state = EMC_READY;
        else if (s_reg.rmw)
        begin
          // Read phase over: full-word write follows
          s_next.rmw = 1'b0;
          s_next.ext_write = 1'b1;
          s_next.wcnt = {3'h0, c2[`EMC_C2_RAMWWS +: 2]};
          s_next.state = EMC_WAIT;
        end
        else
        begin
          s_next.done = 1'b1;
          s_next.state = EMC_IDLE;
        end
        // Bus error ends the access at once with the matching trap
        if (bus_err)
        begin
          s_next.done = 1'b1;
          s_next.err = 1'b1;
          s_next.rmw = 1'b0;
          s_next.trap = s_reg.acc_fetch ? `EMC_TRAP_FETCH :
                        (s_reg.acc_write ? `EMC_TRAP_STORE : `EMC_TRAP_LOAD);
          s_next.state = EMC_IDLE;
        end
        if (s_next.state == EMC_IDLE)
        begin
          s_next.ext_active = 1'b0;
          s_next.ext_write = 1'b0;
          s_next.cs_n = 5'h1_F;
        end
      end
      default:
        s_next.state = EMC_IDLE;
    endcase

    // SDRAM refresh timer
    if (c2[`EMC_C2_SDRREF] && dram_ctrl_enable)
    begin
      if (s_reg.ref_cnt == 16'h0000)
      begin
        s_next.ref_cnt = 16'(REFRESH_CYCLES - 1);
        s_next.ref_pend = 1'b1;
      end
      else
        s_next.ref_cnt = s_reg.ref_cnt - 16'h0001;
    end
    else
    begin
      s_next.ref_cnt = 16'(REFRESH_CYCLES - 1);
      s_next.ref_pend = 1'b0;
    end

    // SDRAM command engine; software commands take precedence over refresh
    if (s_reg.sd_busy)
    begin
      if (s_reg.sd_cnt == 4'h0)
      begin
        s_next.sd_busy = 1'b0;
        if (s_reg.sd_sw)
          s_next.cfg2[`EMC_C2_SDRCMD +: 2] = 2'b00;
      end
      else
        s_next.sd_cnt = s_reg.sd_cnt - 4'h1;
    end
    // A refresh left pending when refresh is switched off is dropped, not issued
    else if (dram_ctrl_enable && s_reg.state == EMC_IDLE &&
             (sw_cmd != 2'b00 || (s_reg.ref_pend && c2[`EMC_C2_SDRREF])))
    begin
      s_next.sd_busy = 1'b1;
      s_next.sd_sw = (sw_cmd != 2'b00);
      s_next.sd_cmd = (sw_cmd != 2'b00) ? emc_sdcmd_t'(sw_cmd) : EMC_SD_REFRESH;
      if (sw_cmd == 2'b00)
        s_next.ref_pend = 1'b0;
      unique case (s_next.sd_cmd)
        EMC_SD_PRECHARGE:
          sd_t = 4'(`EMC_TRP_BASE) + {3'h0, c2[`EMC_C2_TRP]};
        EMC_SD_REFRESH:
          sd_t = 4'(`EMC_TRFC_BASE) + {1'b0, c2[`EMC_C2_TRFC +: 3]};
        default:
          sd_t = 4'(`EMC_TLMR_CYC);
      endcase
      s_next.sd_cnt = sd_t - 4'h1;
    end

    // Register writes; a software write wins over the hardware clear
    if (i_reg_wr && i_reg_addr == `EMC_OFS_CFG_ONE)
      s_next.cfg1 = i_reg_wdata & `EMC_CFG1_WMASK;
    if (i_reg_wr && i_reg_addr == `EMC_OFS_CFG_TWO)
      s_next.cfg2 = i_reg_wdata & `EMC_CFG2_WMASK;

    // Geometry decode, one clock behind the registers
    s_next.cas_lat = 2'(`EMC_CAS_BASE) + {1'b0, c2[`EMC_C2_SDRCAS]};
    s_next.sd_bank_log2 = 5'd22 + {2'b00, c2[`EMC_C2_SDRBS +: 3]};
    if (c2[`EMC_C2_SDRCLS +: 2] == 2'b11)
      s_next.sd_col_log2 = (c2[`EMC_C2_SDRBS +: 3] == 3'b111) ? 4'd12 : 4'd11;
    else
      s_next.sd_col_log2 = 4'd8 + {2'b00, c2[`EMC_C2_SDRCLS +: 2]};
    s_next.sram_bank_log2 = 5'd13 + {1'b0, c2[`EMC_C2_RAMBS +: 4]};
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      s_reg <= '0;
      s_reg.cfg1 <= `EMC_CFG1_RESET;
      s_reg.cfg2 <= `EMC_CFG2_RESET;
      s_reg.rdy_meta <= 1'b1;
      s_reg.rdy_sync <= 1'b1;
      s_reg.state <= EMC_IDLE;
      s_reg.cs_n <= 5'h1_F;
      s_reg.sd_cmd <= EMC_SD_NONE;
      s_reg.acc_area <= EMC_AREA_PROM;
    end
    else
      s_reg <= s_next;
  end

  // Outputs straight from the state register
  assign o_reg_rdata = s_reg.rdata;
  assign o_acc_done = s_reg.done;
  assign o_acc_err = s_reg.err;
  assign o_trap_code = s_reg.trap;
  assign o_ext_active = s_reg.ext_active;
  assign o_ext_write = s_reg.ext_write;
  assign o_ext_width8 = s_reg.width8;
  assign o_static_chip_select_n = s_reg.cs_n;
  assign o_sd_cmd = s_reg.sd_cmd;
  assign o_sd_cas_latency = s_reg.cas_lat;
  assign o_sd_bank_log2 = s_reg.sd_bank_log2;
  assign o_sd_col_log2 = s_reg.sd_col_log2;
  assign o_sram_bank_log2 = s_reg.sram_bank_log2;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking chk_cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_reset_n);

  // Counts cycles with the external strobe up for the wait-state checks
  logic [5:0] act_cnt;
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
      act_cnt <= 6'h00;
    else if (s_reg.ext_active)
      act_cnt <= act_cnt + 6'h01;
    else
      act_cnt <= 6'h00;
  end

  chk_io_disable_block: assert property (
    s_reg.state == EMC_IDLE && i_acc_req && i_acc_area == EMC_AREA_IO && !c1[`EMC_C1_IOEN]
    |=> o_acc_done && o_acc_err && !o_ext_active)
    else $error("I/O access not refused while area disabled");

  chk_prom_write_block: assert property (
    s_reg.state == EMC_IDLE && i_acc_req && i_acc_area == EMC_AREA_PROM && i_acc_write &&
    !c1[`EMC_C1_PRWEN] |=> o_acc_err && o_trap_code == `EMC_TRAP_STORE)
    else $error("PROM write allowed with write enable clear");

  chk_prom_ready_wait: assert property (
    s_reg.state == EMC_READY && s_reg.acc_area == EMC_AREA_PROM && !rdy_seen && !bus_err
    |=> !o_acc_done && o_ext_active)
    else $error("PROM access ended before ready");

  chk_io_wait_count: assert property (
    o_ext_active && !o_ext_write && s_reg.acc_area == EMC_AREA_IO && !s_reg.need_rdy &&
    !bus_err && s_next.done |-> act_cnt == {2'b00, c1[`EMC_C1_IOWS +: 4]})
    else $error("I/O wait states wrong");

  chk_prom_wait_count: assert property (
    o_ext_active && !o_ext_write && s_reg.acc_area == EMC_AREA_PROM && !s_reg.need_rdy &&
    !bus_err && s_next.done |-> act_cnt == {1'b0, c1[`EMC_C1_PRRWS +: 4], 1'b0})
    else $error("PROM read wait states wrong");

  chk_bexc_store_trap: assert property (
    s_reg.state != EMC_IDLE && bus_err && s_reg.acc_write && !s_reg.acc_fetch
    |=> o_acc_err ##1 !o_ext_active)
    else $error("Bus error did not end store with error");

  chk_async_ready_delay: assert property (
    c1[`EMC_C1_ABRDY] && s_reg.state == EMC_READY && $fell(i_ext_ready_n) && !bus_err
    |-> !s_next.done)
    else $error("Async ready ended access too soon");

  chk_refresh_gate: assert property (
    o_sd_cmd == EMC_SD_REFRESH && !s_reg.sd_sw |-> $past(c2[`EMC_C2_SDRREF]))
    else $error("Auto-refresh with refresh disabled");

  chk_precharge_time: assert property (
    o_sd_cmd == EMC_SD_PRECHARGE && !c2[`EMC_C2_TRP] && !i_reg_wr
    |-> s_reg.sd_busy ##1 s_reg.sd_busy ##1 !s_reg.sd_busy)
    else $error("Precharge time not two clocks");

  chk_cmd_field_clear: assert property (
    s_reg.sd_busy && s_reg.sd_cnt == 4'h0 && s_reg.sd_sw && !i_reg_wr
    |=> c2[`EMC_C2_SDRCMD +: 2] == 2'b00)
    else $error("Command field not cleared");

  chk_cas_follow: assert property (
    $past(i_reset_n) |->
    o_sd_cas_latency == 2'(`EMC_CAS_BASE) + {1'b0, $past(c2[`EMC_C2_SDRCAS])})
    else $error("CAS latency does not follow config");

  chk_sram_disable: assert property (
    s_reg.state == EMC_IDLE && i_acc_req && i_acc_area == EMC_AREA_SRAM && sram_off
    |=> o_acc_err && o_static_chip_select_n == 5'h1_F)
    else $error("Static access while disabled");

endmodule
`default_nettype wire

// ### verif/emc_ext_dev.sv
// Behavioural external device on the shared bus: ready and bus error
`timescale 1ns/1ps
`default_nettype none
module emc_ext_dev
(
  input wire logic i_clk_sys,
  input wire logic i_ext_active,
  input wire logic [3:0] i_ready_delay,
  input wire logic i_error_mode,
  output logic o_ext_ready_n,
  output logic o_ext_error_n
);
  logic [3:0] cnt = 4'h0;
  // ------------------------------------------------------------
  // Answer an access after a set number of active cycles
  // ------------------------------------------------------------
  // Lines sit on pull-ups, so they go high on the clock after the access ends
  initial o_ext_ready_n = 1'b1;
  initial o_ext_error_n = 1'b1;
  always @(posedge i_clk_sys)
  begin
    if (!i_ext_active)
    begin
      cnt <= 4'h0;
      o_ext_ready_n <= 1'b1;
      o_ext_error_n <= 1'b1;
    end
    else
    begin
      cnt <= (cnt == 4'hF) ? cnt : cnt + 4'h1;
      // Held low until the access ends, well beyond 1.5 cycles
      o_ext_ready_n <= !(cnt >= i_ready_delay);
      o_ext_error_n <= !i_error_mode;
    end
  end
endmodule
`default_nettype wire

// ### verif/tb.sv
// Self-checking bench of the memory configuration block
`timescale 1ns/1ps
`default_nettype none
`include "emc_defs.svh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin err_total++; $display("Error %s exp %0h got %0h", nm, e, g); end end
module tb;
  import emc_pkg::*;
  typedef struct {logic [31:0] c1; logic [31:0] c2; emc_area_t ar; logic wr; logic sb;
    logic [2:0] bk; logic [27:0] off; int act; logic er; logic w8;} emc_tb_row_t;
  logic i_clk_sys = 1'b0;
  logic i_reset_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0, rd = 1'b0, req = 1'b0, a_wr = 1'b0, a_ft = 1'b0, a_sb = 1'b0;
  emc_area_t a_ar = EMC_AREA_PROM;
  logic [2:0] a_bk = 3'h0;
  logic [27:0] a_off = 28'h000_0000;
  logic [3:0] rdy_dly = 4'h0;
  logic err_mode = 1'b0;
  logic ready_n, error_n, done, aerr, active, w8;
  logic [31:0] rdata;
  logic [7:0] trap;
  logic [4:0] cs_n, sd_bl, ram_bl;
  logic [4:0] cs_seen, cs_exp;
  logic ws_seen, ewr;
  logic edac = 1'b1;
  logic [1:0] strap = 2'b10;
  logic [3:0] sd_cl;
  logic [1:0] cas;
  emc_sdcmd_t sd_cmd;
  int err_total = 0;
  int checks_done = 0;
  int n, k, j;
  logic e, m;
  logic [31:0] v;
  emc_tb_row_t rows[17] = '{
    '{32'h0018_0000, 32'h0000_0000, EMC_AREA_IO, 0, 0, 0, 0, 2, 0, 1},
    '{32'h10F8_0000, 32'h0000_0000, EMC_AREA_IO, 0, 0, 0, 0, 16, 0, 0},
    '{32'h0000_0000, 32'h0000_0000, EMC_AREA_IO, 1, 0, 0, 0, 0, 1, 1'bx},
    '{32'h0008_0000, 32'h0000_0000, EMC_AREA_IO, 1, 0, 0, 0, 1, 0, 1},
    '{32'h0000_0001, 32'h0000_0000, EMC_AREA_PROM, 0, 0, 0, 0, 3, 0, 1},
    '{32'h0000_0011, 32'h0000_0000, EMC_AREA_PROM, 1, 0, 0, 0, 0, 1, 1'bx},
    '{32'h0000_0811, 32'h0000_0000, EMC_AREA_PROM, 1, 0, 0, 0, 3, 0, 1},
    '{32'h0000_0000, 32'h0000_0000, EMC_AREA_PROM, 0, 0, 0, 204, 1, 0, 1},
    '{32'h0000_0000, 32'h0000_0000, EMC_AREA_PROM, 0, 0, 0, 205, 0, 1, 1'bx},
    '{32'h0000_0000, 32'h0000_0003, EMC_AREA_SRAM, 0, 0, 0, 0, 4, 0, 1},
    '{32'h0000_0000, 32'h0000_0028, EMC_AREA_SRAM, 1, 0, 0, 0, 3, 0, 0},
    '{32'h0000_0000, 32'h0000_0049, EMC_AREA_SRAM, 1, 1, 0, 0, 5, 0, 1},
    '{32'h0000_0000, 32'h0000_6000, EMC_AREA_SRAM, 0, 0, 0, 0, 0, 1, 1'bx},
    '{32'h0000_0000, 32'h0000_0000, EMC_AREA_SRAM, 0, 0, 5, 0, 0, 1, 1'bx},
    '{32'h0000_0000, 32'h0000_0000, EMC_AREA_SDRAM, 0, 0, 0, 0, 0, 1, 1'bx},
    '{32'h0000_0000, 32'h0000_4000, EMC_AREA_SDRAM, 0, 0, 0, 0, 3, 0, 1'bx},
    '{32'h0000_0000, 32'h0400_4000, EMC_AREA_SDRAM, 0, 0, 0, 0, 4, 0, 1'bx}};
  // Small counts keep refresh and the PROM bank boundary quick to reach
  emc_core #(.PROM_BANK_LOG2(8), .REFRESH_CYCLES(8)) DUT (.i_clk_sys(i_clk_sys),
    .i_reset_n(i_reset_n), .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr),
    .i_reg_rd(rd), .o_reg_rdata(rdata), .i_strap_prom_width(strap), .i_prom_edac_en(edac),
    .i_acc_req(req), .i_acc_area(a_ar), .i_acc_write(a_wr), .i_acc_fetch(a_ft),
    .i_acc_subword(a_sb), .i_acc_bank(a_bk), .i_acc_offset(a_off), .o_acc_done(done),
    .o_acc_err(aerr), .o_trap_code(trap), .i_ext_ready_n(ready_n), .i_ext_error_n(error_n),
    .o_ext_active(active), .o_ext_write(ewr), .o_ext_width8(w8), .o_static_chip_select_n(cs_n),
    .o_sd_cmd(sd_cmd), .o_sd_cas_latency(cas), .o_sd_bank_log2(sd_bl),
    .o_sd_col_log2(sd_cl), .o_sram_bank_log2(ram_bl));
  emc_ext_dev PEER (.i_clk_sys(i_clk_sys), .i_ext_active(active), .i_ready_delay(rdy_dly),
    .i_error_mode(err_mode), .o_ext_ready_n(ready_n), .o_ext_error_n(error_n));
  // ------------------------------------------------------------
  // Clock, bus tasks and verdict
  // ------------------------------------------------------------
  initial forever #25 i_clk_sys = ~i_clk_sys;
  task automatic do_reset();
    i_reset_n <= 1'b0;
    repeat (20) @(posedge i_clk_sys);
    i_reset_n <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge i_clk_sys);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk_sys);
    rd <= 1'b1;
    addr <= a;
    @(posedge i_clk_sys);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // One access; counts active cycles, keeps the width seen while active
  task automatic acc(input emc_area_t ar, input logic w, input logic f, input logic s,
    input logic [2:0] b, input logic [27:0] o, output int cnt, output logic er, output logic b8);
    int i;
    cnt = 0;
    er = 1'bx;
    b8 = 1'bx;
    cs_seen = 'x;
    ws_seen = 1'bx;
    @(posedge i_clk_sys);
    {req, a_ar, a_wr, a_ft, a_sb, a_bk, a_off} <= {1'b1, ar, w, f, s, b, o};
    @(posedge i_clk_sys);
    req <= 1'b0;
    for (i = 0; i < 200; i++)
    begin
      #1;
      if (done === 1'b1)
      begin
        er = aerr;
        break;
      end
      if (active === 1'b1)
      begin
        cnt++;
        b8 = w8;
        cs_seen = cs_n;
        ws_seen = ewr;
      end
      @(posedge i_clk_sys);
    end
  endtask
  task automatic tally_and_finish();
    if (err_total == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Watchdog well past the few hundred cycles the run needs
  initial
  begin
    #2_000_000;
    err_total++;
    tally_and_finish();
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    do_reset();
    reg_rd(`EMC_OFS_CFG_ONE, v);
    `CHK("cfg1 reset", 32'h0000_02FF, v)
    reg_rd(`EMC_OFS_CFG_TWO, v);
    `CHK("cfg2 reset", 32'h7C40_0000, v)
    `CHK("sd bank", 5'd22, sd_bl)
    reg_wr(`EMC_OFS_CFG_ONE, 32'hFFFF_FFFF);
    reg_wr(`EMC_OFS_CFG_TWO, 32'hFFE7_FFFF);
    reg_rd(`EMC_OFS_CFG_ONE, v);
    `CHK("cfg1 mask", 32'h7EF8_0BFF, v)
    reg_rd(`EMC_OFS_CFG_TWO, v);
    `CHK("cfg2 mask", 32'hFFE0_7EFF, v)
    reg_rd(8'h08, v);
    `CHK("unmapped", 32'h0000_0000, v)
    `CHK("sd bank max", 5'd29, sd_bl)
    `CHK("sd col", 4'd12, sd_cl)
    `CHK("ram bank", 5'd28, ram_bl)
    `CHK("cas", 2'd3, cas)
    reg_wr(`EMC_OFS_CFG_TWO, 32'h0060_0000);
    repeat (2) @(posedge i_clk_sys);
    `CHK("sd col 11", 4'd11, sd_cl)
    foreach (rows[i])
    begin
      reg_wr(`EMC_OFS_CFG_ONE, rows[i].c1);
      reg_wr(`EMC_OFS_CFG_TWO, rows[i].c2);
      acc(rows[i].ar, rows[i].wr, 1'b0, rows[i].sb, rows[i].bk, rows[i].off, n, e, m);
      `CHK("active cycles", rows[i].act, n)
      `CHK("refused", rows[i].er, e)
      if (rows[i].w8 !== 1'bx) `CHK("width8", rows[i].w8, m)
      // Last active cycle: write phase and chip select of the area
      cs_exp = (rows[i].ar == EMC_AREA_SRAM) ? ~(5'h01 << rows[i].bk) : 5'h1F;
      if (!rows[i].er) `CHK("write phase", rows[i].wr, ws_seen)
      if (!rows[i].er) `CHK("chip select", cs_exp, cs_seen)
    end
    // Ready extension, sync then async, PROM, IO and RAM bank 4
    rdy_dly = 4'h6;
    for (k = 0; k < 4; k++)
    begin
      reg_wr(`EMC_OFS_CFG_ONE, k == 2 ? 32'h0408_0000 : (k == 1 ? 32'h6000_0000 : 32'h4000_0000));
      reg_wr(`EMC_OFS_CFG_TWO, 32'h0000_0080);
      acc(k == 2 ? EMC_AREA_IO : (k == 3 ? EMC_AREA_SRAM : EMC_AREA_PROM), 0, 0, 0, 4, 0, n, e, m);
      `CHK("ready wait", 1'b1, n > 6 + k % 2)
    end
    acc(EMC_AREA_SRAM, 1'b0, 1'b0, 1'b0, 3'h3, 28'h0, n, e, m);
    `CHK("bank3 no wait", 1, n)
    `CHK("bank3 select", 5'h17, cs_seen)
    rdy_dly = 4'h0;
    // Bus error on every access type, then with trapping off
    err_mode = 1'b1;
    // One I/O wait state so the access is still open when the device flags the error
    reg_wr(`EMC_OFS_CFG_ONE, 32'h0218_0000);
    for (k = 0; k < 3; k++)
    begin
      acc(EMC_AREA_IO, k == 2, k == 0, 1'b0, 3'h0, 28'h0, n, e, m);
      `CHK("bus error", 1'b1, e)
      `CHK("trap", k == 0 ? 8'h01 : (k == 1 ? 8'h09 : 8'h2B), trap)
    end
    reg_wr(`EMC_OFS_CFG_ONE, 32'h0008_0000);
    acc(EMC_AREA_IO, 1'b0, 1'b0, 1'b0, 3'h0, 28'h0, n, e, m);
    `CHK("error off", 1'b0, e)
    // Without error correction the top fifth of the bank is usable
    edac <= 1'b0;
    acc(EMC_AREA_PROM, 1'b0, 1'b0, 1'b0, 3'h0, 28'd205, n, e, m);
    `CHK("edac off", 1'b0, e)
    err_mode = 1'b0;
    // Every software SDRAM command, then field clears
    for (k = 1; k < 4; k++)
    begin
      reg_wr(`EMC_OFS_CFG_TWO, 32'h0000_4000 | (k << 19));
      v = 0;
      for (j = 0; j < 10; j++)
      begin
        #1 if (sd_cmd !== EMC_SD_NONE) v = sd_cmd;
        @(posedge i_clk_sys);
      end
      `CHK("sd cmd", k, v)
      reg_rd(`EMC_OFS_CFG_TWO, v);
      `CHK("cmd cleared", 32'h0000_4000, v)
    end
    // Periodic refresh only while enabled
    for (k = 0; k < 2; k++)
    begin
      reg_wr(`EMC_OFS_CFG_TWO, k ? 32'h0000_4000 : 32'h8000_4000);
      n = 0;
      repeat (40)
      begin
        @(posedge i_clk_sys);
        #1 if (sd_cmd === EMC_SD_REFRESH) n++;
      end
      `CHK("refresh count", k ? 1'b1 : 1'b1, k ? n == 0 : (n >= 4 && n <= 5))
    end
    // Reset in mid-run restores boot values
    reg_wr(`EMC_OFS_CFG_ONE, 32'h0000_0000);
    strap <= 2'b00;
    do_reset();
    reg_rd(`EMC_OFS_CFG_ONE, v);
    `CHK("cfg1 rereset", 32'h0000_00FF, v)
    tally_and_finish();
  end
endmodule
`default_nettype wire
